/* File: core/slave_service_regs.svh */
// Register indices, field positions and codes of the slave service block.
// Assumes word addressing on the register bus: one index per 32-bit word.
`ifndef SLAVE_SERVICE_REGS_SVH
`define SLAVE_SERVICE_REGS_SVH
// -----------------------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------------------
`define IDX_LIST_BASE 9'h017
`define IDX_GC_CELL 9'h03C
`define IDX_MODE0 9'h020
`define IDX_MODE1 9'h021
`define IDX_MODE2 9'h022
`define IDX_STATUS 9'h023
`define RAM_SEL_BIT 8
// -----------------------------------------------------------------------------
// Mode and status fields
// -----------------------------------------------------------------------------
`define M0_SYNC_EN 0
`define M0_FREEZE_EN 1
`define M0_EXT_PRM_EN 2
`define M0_FAILSAFE_REQ 3
`define M1_CHANGE_CFG 0
`define M1_GO_OFFLINE 1
`define M2_GC_ON_CHANGE 8
`define GC_SYNC 5
`define GC_UNSYNC 4
`define GC_FREEZE 3
`define GC_UNFREEZE 2
`define GC_CLEAR 1
`define PS1_ACYC_EN 7
`define PS1_FAILSAFE 6
// -----------------------------------------------------------------------------
// Service list and buffer layout
// -----------------------------------------------------------------------------
`define ENTRY_SIZE 8'h07
`define ENTRY_SA 8'h01
`define ENTRY_SSAP 8'h02
`define ENTRY_SVC 8'h03
`define ENTRY_IND0 8'h04
`define ENTRY_IND1 8'h05
`define ENTRY_RESP 8'h06
`define LIST_END 8'hFF
`define ADDR_ANY 8'h7F
`define SVC_ANY 8'h00
`define SAP_MAX 6'h33
`define ENTRY_SENT 7
`define HDR_LEN 8'h02
`define HDR_FC 8'h03
`define CTL_USER 7
`define CTL_IND 6
`define CTL_RESP 5
`define CTL_DEVICE_OWNED_FLAG 4
`define MODE_RESET 16'h0000
`endif

/* File: core/slave_service_pkg.sv */
// Types shared by the slave service block and its bench.
// Assumes slave_service_regs.svh supplies every numeric constant.
package slave_service_pkg;
   typedef enum logic [3:0] {
      K_GC = 4'h0, K_RD_IN = 4'h1, K_RD_OUT = 4'h2, K_GET_CFG = 4'h3,
      K_SET_PRM = 4'h4, K_EXT_PRM = 4'h5, K_CHK_CFG = 4'h6,
      K_AC_REQ = 4'h7, K_AC_POLL = 4'h8, K_DX = 4'h9
   } kind_t;
   typedef enum logic [2:0] {
      A_ACK = 3'h0, A_NO_SERVICE = 3'h1, A_NO_RESOURCE = 3'h2,
      A_RESPONSE = 3'h3, A_BUFFER = 3'h4
   } ans_t;
   typedef enum logic [7:0] {
      S_IDLE = 8'h01, S_SCAN = 8'h02, S_IND_SEL = 8'h04, S_IND_LEN = 8'h08,
      S_IND_FC = 8'h10, S_IND_DONE = 8'h20, S_POLL_CLR = 8'h40, S_POLL_SENT = 8'h80
   } state_t;
endpackage

/* File: core/slave_service.sv */
// Slave service logic: global control, input/output reads, configuration
// swap, parameter checks and the acyclic service list engine.
// Assumes a link layer on the same clock delivering decoded telegrams.
`timescale 1ns/1ns
`include "slave_service_regs.svh"
module slave_service
   import slave_service_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic tg_valid,
   output logic tg_ready,
   input wire logic [3:0] tg_kind,
   input wire logic [7:0] tg_byte0,
   input wire logic [7:0] tg_byte1,
   input wire logic [7:0] tg_status1,
   input wire logic [7:0] tg_status2,
   input wire logic [7:0] tg_status3,
   input wire logic [7:0] tg_src_addr,
   input wire logic [7:0] tg_src_sap,
   input wire logic [5:0] tg_dst_sap,
   input wire logic [7:0] tg_fc,
   input wire logic [7:0] tg_len,
   input wire logic in_wait_cfg,
   input wire logic din_new_avail,
   input wire logic [1:0] user_dout_buf,
   output logic ans_valid,
   output logic [2:0] ans_code,
   output logic [7:0] ans_ptr,
   output logic dout_move,
   output logic dout_clear,
   output logic din_fetch,
   output logic cfg_swap,
   output logic go_offline,
   output logic global_command_received_irq,
   output logic ext_prm_irq,
   output logic acyclic_request_irq,
   output logic poll_end_irq,
   output logic prm_fault
);
   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   logic [7:0] mem_q [0:255];
   logic [7:0] base_q, gc_cell_q, gc_prev_q, grp_prev_q;
   logic [15:0] mode0_q, mode1_q, mode2_q;
   logic [7:0] ps1_q, ps2_q, ps3_q;
   logic sync_q, freeze_q, fault_q, prm_seen_q, gc_seen_q, done_q;
   logic [31:0] rdata_q;
   state_t st_q, st_d;
   logic [7:0] ea_q, buf_q;
   logic [7:0] src_q, ssap_q, fc_q, len_q;
   logic [5:0] dsap_q;
   logic poll_q;
   logic ans_v_q, mv_q, clr_q, fetch_q, swap_q, off_q;
   logic gc_irq_q, ext_irq_q, ind_irq_q, pe_irq_q;
   logic [2:0] code_q;
   logic [7:0] ptr_q;

   // -------------------------------------------------------------------------
   // Register bus decode
   // -------------------------------------------------------------------------
   wire bus_req = avs_read | avs_write;
   wire bus_go = bus_req & (st_q == S_IDLE) & ~done_q;
   wire bus_wr = avs_write & done_q;
   wire ram_sel = avs_address[`RAM_SEL_BIT];
   wire [7:0] ram_a = avs_address[7:0];
   wire wr_base = bus_wr & (avs_address == `IDX_LIST_BASE);
   wire wr_gc = bus_wr & (avs_address == `IDX_GC_CELL);
   wire wr_m0 = bus_wr & (avs_address == `IDX_MODE0);
   wire wr_m1 = bus_wr & (avs_address == `IDX_MODE1);
   wire wr_m2 = bus_wr & (avs_address == `IDX_MODE2);
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (ram_sel) begin
         rmux = {24'h00_0000, mem_q[ram_a]};
      end else begin
         unique case (avs_address)
            `IDX_LIST_BASE: rmux = {24'h00_0000, base_q};
            `IDX_GC_CELL: rmux = {24'h00_0000, gc_cell_q};
            `IDX_MODE0: rmux = {16'h0000, mode0_q};
            `IDX_MODE1: rmux = {16'h0000, mode1_q};
            `IDX_MODE2: rmux = {16'h0000, mode2_q};
            `IDX_STATUS: rmux = {5'h00, ps3_q, ps2_q, ps1_q, fault_q, freeze_q, sync_q};
            default: rmux = 32'h0000_0000;
         endcase
      end
   end
   assign avs_waitrequest = bus_req & ~done_q;
   assign avs_readdata = rdata_q;

   // -------------------------------------------------------------------------
   // Telegram decode
   // -------------------------------------------------------------------------
   assign tg_ready = (st_q == S_IDLE);
   wire take = tg_valid & tg_ready;
   wire is_gc = take & (tg_kind == K_GC);
   wire [7:0] gc_grp = mode2_q[7:0];
   wire gc_hit = (tg_byte1 == 8'h00) | (|(tg_byte1 & gc_grp));
   wire gc_changed = ~gc_seen_q | (tg_byte0 != gc_prev_q) | (tg_byte1 != grp_prev_q);
   wire gc_irq = is_gc & (~mode2_q[`M2_GC_ON_CHANGE] | gc_changed);
   wire gc_act = is_gc & gc_hit;
   wire do_sync = gc_act & mode0_q[`M0_SYNC_EN] & tg_byte0[`GC_SYNC];
   wire do_unsync = gc_act & mode0_q[`M0_SYNC_EN] & tg_byte0[`GC_UNSYNC];
   wire do_freeze = gc_act & mode0_q[`M0_FREEZE_EN] & tg_byte0[`GC_FREEZE];
   wire do_unfreeze = gc_act & mode0_q[`M0_FREEZE_EN] & tg_byte0[`GC_UNFREEZE];
   wire do_clear = gc_act & tg_byte0[`GC_CLEAR];
   wire dx_move = take & (tg_kind == K_DX) & ~sync_q;
   wire rd_in = take & (tg_kind == K_RD_IN);
   wire in_fetch = rd_in & ~freeze_q & din_new_avail;
   wire is_prm = take & (tg_kind == K_SET_PRM);
   wire fs_fault = mode0_q[`M0_FAILSAFE_REQ] & ~tg_status1[`PS1_FAILSAFE];
   wire is_ext = take & (tg_kind == K_EXT_PRM);
   wire ext_ok = is_ext & in_wait_cfg & prm_seen_q & mode0_q[`M0_EXT_PRM_EN];
   wire is_ac = take & ((tg_kind == K_AC_REQ) | (tg_kind == K_AC_POLL));
   wire ac_en = ps1_q[`PS1_ACYC_EN];
   wire swap_now = mode1_q[`M1_CHANGE_CFG];

   // -------------------------------------------------------------------------
   // Service list engine reads
   // -------------------------------------------------------------------------
   wire [7:0] e0 = mem_q[ea_q];
   wire [7:0] e_sa = mem_q[8'(ea_q + `ENTRY_SA)];
   wire [7:0] e_ssap = mem_q[8'(ea_q + `ENTRY_SSAP)];
   wire [7:0] e_svc = mem_q[8'(ea_q + `ENTRY_SVC)];
   wire [7:0] p_ind0 = mem_q[8'(ea_q + `ENTRY_IND0)];
   wire [7:0] p_ind1 = mem_q[8'(ea_q + `ENTRY_IND1)];
   wire [7:0] p_resp = mem_q[8'(ea_q + `ENTRY_RESP)];
   wire [7:0] c_ind0 = mem_q[p_ind0];
   wire [7:0] c_ind1 = mem_q[p_ind1];
   wire [7:0] c_resp = mem_q[p_resp];
   wire [7:0] c_buf = mem_q[buf_q];
   wire list_end = (e0 == `LIST_END);
   wire sap_hit = (e0[5:0] == dsap_q) & (e0[5:0] <= `SAP_MAX);
   wire sa_ok = (e_sa == `ADDR_ANY) | (e_sa == src_q);
   wire ssap_ok = (e_ssap == `ADDR_ANY) | (e_ssap == ssap_q);
   wire svc_ok = (e_svc == `SVC_ANY) | (e_svc == fc_q);
   wire entry_ok = sa_ok & ssap_ok & svc_ok;
   wire free0 = c_ind0[`CTL_DEVICE_OWNED_FLAG] & ~c_ind0[`CTL_USER];
   wire free1 = c_ind1[`CTL_DEVICE_OWNED_FLAG] & ~c_ind1[`CTL_USER];
   wire resp_rdy = c_resp[`CTL_RESP];

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         S_IDLE: if (is_ac & ac_en) st_d = S_SCAN;
         S_SCAN: begin
            if (list_end) st_d = S_IDLE;
            else if (sap_hit & ~entry_ok) st_d = S_IDLE;
            else if (sap_hit & poll_q) st_d = resp_rdy ? S_POLL_CLR : S_IDLE;
            else if (sap_hit) st_d = (free0 | free1) ? S_IND_SEL : S_IDLE;
         end
         S_IND_SEL: st_d = S_IND_LEN;
         S_IND_LEN: st_d = S_IND_FC;
         S_IND_FC: st_d = S_IND_DONE;
         S_IND_DONE: st_d = S_IDLE;
         S_POLL_CLR: st_d = S_POLL_SENT;
         S_POLL_SENT: st_d = S_IDLE;
      endcase
   end

   // Engine writes at most one byte per state so the shared memory keeps one port.
   logic eng_we;
   logic [7:0] eng_wa, eng_wd;
   always_comb begin
      eng_we = 1'b1;
      eng_wa = buf_q;
      eng_wd = c_buf;
      unique case (st_q)
         S_IND_SEL: eng_wd = c_buf;
         S_IND_LEN: begin
            eng_wa = 8'(buf_q + `HDR_LEN);
            eng_wd = len_q;
         end
         S_IND_FC: begin
            eng_wa = 8'(buf_q + `HDR_FC);
            eng_wd = fc_q;
         end
         S_IND_DONE: begin
            eng_wd = c_buf;
            eng_wd[`CTL_DEVICE_OWNED_FLAG] = 1'b0;
            eng_wd[`CTL_USER] = 1'b1;
            eng_wd[`CTL_IND] = 1'b1;
         end
         S_POLL_CLR: begin
            eng_wd = c_buf;
            eng_wd[`CTL_RESP] = 1'b0;
            eng_wd[`CTL_USER] = 1'b0;
         end
         S_POLL_SENT: begin
            eng_wa = ea_q;
            eng_wd = e0;
            eng_wd[`ENTRY_SENT] = 1'b1;
         end
         default: eng_we = 1'b0;
      endcase
      if (st_q == S_IND_SEL) eng_we = 1'b0;
   end

   // -------------------------------------------------------------------------
   // Memory and bus registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (eng_we) begin
         mem_q[eng_wa] <= eng_wd;
      end else if (bus_wr & ram_sel) begin
         mem_q[ram_a] <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         done_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         base_q <= 8'h00;
         mode0_q <= `MODE_RESET;
         mode1_q <= `MODE_RESET;
         mode2_q <= `MODE_RESET;
      end else begin
         done_q <= bus_go;
         if (bus_go) rdata_q <= rmux;
         if (wr_base) base_q <= avs_writedata[7:0];
         if (wr_m0) mode0_q <= avs_writedata[15:0];
         if (wr_m2) mode2_q <= avs_writedata[15:0];
         // The mode1 bits are one-shot requests, consumed the cycle after set.
         if (wr_m1) mode1_q <= avs_writedata[15:0];
         else mode1_q <= 16'h0000;
      end
   end

   // The command cell is left alone at reset; firmware presets it.
   always_ff @(posedge clk) begin
      if (is_gc) gc_cell_q <= tg_byte0;
      else if (wr_gc) gc_cell_q <= avs_writedata[7:0];
   end

   // -------------------------------------------------------------------------
   // Service state
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         sync_q <= 1'b0;
         freeze_q <= 1'b0;
         fault_q <= 1'b0;
         prm_seen_q <= 1'b0;
         gc_seen_q <= 1'b0;
         gc_prev_q <= 8'h00;
         grp_prev_q <= 8'h00;
         ps1_q <= 8'h00;
         ps2_q <= 8'h00;
         ps3_q <= 8'h00;
      end else begin
         if (is_gc) begin
            gc_seen_q <= 1'b1;
            gc_prev_q <= tg_byte0;
            grp_prev_q <= tg_byte1;
         end
         if (do_sync) sync_q <= 1'b1;
         else if (do_unsync) sync_q <= 1'b0;
         if (do_freeze) freeze_q <= 1'b1;
         else if (do_unfreeze) freeze_q <= 1'b0;
         if (is_prm) begin
            fault_q <= fs_fault;
            prm_seen_q <= 1'b1;
            ps1_q <= tg_status1;
            ps2_q <= tg_status2;
            ps3_q <= tg_status3;
         end else if (take & (tg_kind == K_CHK_CFG)) begin
            prm_seen_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Engine registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= S_IDLE;
         ea_q <= 8'h00;
         buf_q <= 8'h00;
         src_q <= 8'h00;
         ssap_q <= 8'h00;
         dsap_q <= 6'h00;
         fc_q <= 8'h00;
         len_q <= 8'h00;
         poll_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (is_ac) begin
            ea_q <= base_q;
            src_q <= tg_src_addr;
            ssap_q <= tg_src_sap;
            dsap_q <= tg_dst_sap;
            fc_q <= tg_fc;
            len_q <= tg_len;
            poll_q <= (tg_kind == K_AC_POLL);
         end else if ((st_q == S_SCAN) & ~sap_hit) begin
            ea_q <= 8'(ea_q + `ENTRY_SIZE);
         end
         if ((st_q == S_SCAN) & poll_q) buf_q <= p_resp;
         else if (st_q == S_SCAN) buf_q <= free0 ? p_ind0 : p_ind1;
      end
   end

   // -------------------------------------------------------------------------
   // Answers, buffer exchange strobes and events
   // -------------------------------------------------------------------------
   wire scan_fail = (st_q == S_SCAN) & (list_end | (sap_hit & ~entry_ok));
   wire no_res = (st_q == S_SCAN) & sap_hit & entry_ok & ~poll_q & ~(free0 | free1);
   wire poll_idle = (st_q == S_SCAN) & sap_hit & entry_ok & poll_q & ~resp_rdy;
   wire ack_kind = rd_in | is_gc | is_prm | ext_ok | (take & (tg_kind inside {K_GET_CFG, K_CHK_CFG}));
   always_ff @(posedge clk) begin
      if (srst) begin
         ans_v_q <= 1'b0;
         code_q <= A_ACK;
         ptr_q <= 8'h00;
      end else begin
         ans_v_q <= 1'b0;
         if (scan_fail | (is_ac & ~ac_en) | (is_ext & ~ext_ok)) begin
            ans_v_q <= 1'b1;
            code_q <= A_NO_SERVICE;
         end else if (no_res) begin
            ans_v_q <= 1'b1;
            code_q <= A_NO_RESOURCE;
         end else if (poll_idle | (st_q == S_IND_DONE)) begin
            ans_v_q <= 1'b1;
            code_q <= A_ACK;
         end else if (st_q == S_POLL_CLR) begin
            ans_v_q <= 1'b1;
            code_q <= A_RESPONSE;
            ptr_q <= buf_q;
         end else if (take & (tg_kind == K_RD_OUT)) begin
            ans_v_q <= 1'b1;
            code_q <= A_BUFFER;
            ptr_q <= {6'h00, user_dout_buf};
         end else if (ack_kind) begin
            ans_v_q <= 1'b1;
            code_q <= A_ACK;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mv_q <= 1'b0;
         clr_q <= 1'b0;
         fetch_q <= 1'b0;
         swap_q <= 1'b0;
         off_q <= 1'b0;
         gc_irq_q <= 1'b0;
         ext_irq_q <= 1'b0;
         ind_irq_q <= 1'b0;
         pe_irq_q <= 1'b0;
      end else begin
         mv_q <= do_sync | do_unsync | dx_move;
         clr_q <= do_clear;
         fetch_q <= do_freeze | in_fetch;
         swap_q <= swap_now;
         off_q <= mode1_q[`M1_GO_OFFLINE];
         gc_irq_q <= gc_irq;
         ext_irq_q <= ext_ok;
         ind_irq_q <= (st_q == S_IND_DONE);
         pe_irq_q <= (st_q == S_POLL_SENT);
      end
   end

   assign ans_valid = ans_v_q;
   assign ans_code = code_q;
   assign ans_ptr = ptr_q;
   assign dout_move = mv_q;
   assign dout_clear = clr_q;
   assign din_fetch = fetch_q;
   assign cfg_swap = swap_q;
   assign go_offline = off_q;
   assign global_command_received_irq = gc_irq_q;
   assign ext_prm_irq = ext_irq_q;
   assign acyclic_request_irq = ind_irq_q;
   assign poll_end_irq = pe_irq_q;
   assign prm_fault = fault_q;
endmodule // slave_service

/* File: test/slave_service_sva.sv */
// Port-level checks of the slave service block.
// Assumes it is bound to slave_service and sees only its ports.
`timescale 1ns/1ns
module slave_service_sva
   import slave_service_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic tg_valid,
   input wire logic tg_ready,
   input wire logic [3:0] tg_kind,
   input wire logic [7:0] tg_byte0,
   input wire logic [7:0] tg_byte1,
   input wire logic in_wait_cfg,
   input wire logic [1:0] user_dout_buf,
   input wire logic ans_valid,
   input wire logic [2:0] ans_code,
   input wire logic [7:0] ans_ptr,
   input wire logic dout_move,
   input wire logic dout_clear,
   input wire logic din_fetch,
   input wire logic global_command_received_irq,
   input wire logic poll_end_irq
);
   // ----------------
   // Properties
   // ----------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   wire take = tg_valid && tg_ready;
   sequence req_rise_s;
      $rose(avs_read || avs_write);
   endsequence
   sequence ac_take_s;
      take && tg_kind == K_AC_REQ;
   endsequence
   sequence gc_clear_s;
      take && tg_kind == K_GC && tg_byte0[1] && tg_byte1 == 8'h00;
   endsequence
   bus_answer_a:
      assert property (req_rise_s |-> avs_waitrequest ##[1:12] !avs_waitrequest)
      else $error("bus answer missing");
   move_cause_a:
      assert property (dout_move |-> $past(take && (tg_kind == K_GC || tg_kind == K_DX)))
      else $error("move without cause");
   clear_now_a:
      assert property (gc_clear_s |=> dout_clear)
      else $error("clear missing");
   gc_irq_a:
      assert property (global_command_received_irq |-> $past(take && tg_kind == K_GC))
      else $error("command irq without telegram");
   fetch_cause_a:
      assert property (din_fetch |-> $past(take && tg_kind inside {K_GC, K_RD_IN, K_DX}))
      else $error("fetch without cause");
   out_read_a:
      assert property (take && tg_kind == K_RD_OUT |=> ans_valid && ans_code == A_BUFFER
         && ans_ptr == {6'h00, $past(user_dout_buf)})
      else $error("output read answer wrong");
   ext_refuse_a:
      assert property (take && tg_kind == K_EXT_PRM && !in_wait_cfg |=> ans_valid
         && ans_code == A_NO_SERVICE)
      else $error("extended parameters not refused");
   ac_answer_a:
      assert property (ac_take_s |=> !tg_ready && !ans_valid ##[1:40] ans_valid)
      else $error("acyclic answer missing");
   poll_end_a:
      assert property (ans_valid && ans_code == A_RESPONSE |=> poll_end_irq)
      else $error("poll end irq missing");
endmodule // slave_service_sva
bind slave_service slave_service_sva slave_service_sva_inst (.*);

/* File: test/link_source.sv */
// Telegram source standing in for the bus-side link logic.
// Assumes the bench calls send and that tg_ready is combinational.
`timescale 1ns/1ns
module link_source
   import slave_service_pkg::*;
(
   input wire logic clk,
   input wire logic tg_ready,
   output logic tg_valid,
   output logic [3:0] tg_kind,
   output logic [7:0] tg_byte0,
   output logic [7:0] tg_byte1,
   output logic [7:0] tg_status1,
   output logic [7:0] tg_status2,
   output logic [7:0] tg_status3,
   output logic [7:0] tg_src_addr,
   output logic [7:0] tg_src_sap,
   output logic [5:0] tg_dst_sap,
   output logic [7:0] tg_fc,
   output logic [7:0] tg_len
);
   initial begin
      tg_valid = 1'b0;
      tg_kind = K_DX;
      tg_byte0 = 8'h00;
      tg_byte1 = 8'h00;
      tg_status1 = 8'h00;
      tg_status2 = 8'hA5;
      tg_status3 = 8'h3C;
      tg_src_addr = 8'h22;
      tg_src_sap = 8'h31;
      tg_dst_sap = 6'h00;
      tg_fc = 8'h5D;
      tg_len = 8'h04;
   end
   // tg_byte0, tg_status1 and tg_dst_sap are inverted once taken, so a stale value never passes for a live one.
   task automatic send(input logic [3:0] k, input logic [7:0] b0, input logic [7:0] s1,
      input logic [5:0] d);
      @(posedge clk);
      tg_valid <= 1'b1;
      tg_kind <= k;
      tg_byte0 <= b0;
      tg_status1 <= s1;
      tg_dst_sap <= d;
      do @(posedge clk); while (tg_ready !== 1'b1);
      tg_valid <= 1'b0;
      tg_byte0 <= ~b0;
      tg_status1 <= ~s1;
      tg_dst_sap <= ~d;
   endtask
endmodule // link_source

/* File: test/tb_top.sv */
// Self-checking bench for the slave service block with a firmware model.
// Assumes link_source drives the telegram port and the checker is bound.
`timescale 1ns/1ns
`include "slave_service_regs.svh"
module tb_top
   import slave_service_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [8:0] avs_address = 9'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic in_wait_cfg = 1'b0;
   logic din_new_avail = 1'b1;
   logic [1:0] user_dout_buf = 2'h0; // Firmware starts with output buffer 0 as the user buffer.
   logic clr = 1'b0;
   logic [8:0] seen = 9'h000;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, tg_valid, tg_ready, ans_valid, dout_move, dout_clear, din_fetch;
   logic cfg_swap, go_offline, global_command_received_irq, ext_prm_irq;
   logic acyclic_request_irq, poll_end_irq, prm_fault;
   logic [3:0] tg_kind;
   logic [7:0] tg_byte0, tg_byte1, tg_status1, tg_status2, tg_status3, tg_src_addr;
   logic [7:0] tg_src_sap, tg_fc, tg_len, ans_ptr, ptr;
   logic [5:0] tg_dst_sap;
   logic [2:0] ans_code, code;
   logic [7:0] cmds [6] = '{8'h20, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
   int mismatches = 0;
   int checks_done = 0;
   int sync_m = 0;
   int frz_m = 0;
   int q[$];
   slave_service slave_service_inst (.*);
   link_source link_source_inst (.*);
   always #5 clk = ~clk;
   always @(posedge clk) seen <= clr ? 9'h000 : seen | {poll_end_irq, dout_move, dout_clear, din_fetch,
      cfg_swap, go_offline, global_command_received_irq, ext_prm_irq, acyclic_request_irq};
   // ----------------
   // Tasks
   // ----------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic arm();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   task automatic tele(input logic [3:0] k, input logic [7:0] b0,
      input logic [7:0] s1 = 8'hC0, input logic [5:0] d = 6'h05);
      arm();
      link_source_inst.send(k, b0, s1, d);
      while (ans_valid !== 1'b1 && k != K_DX) @(posedge clk);
      code = ans_code;
      ptr = ans_ptr;
      repeat (2) @(posedge clk);
   endtask
   // ----------------
   // Tests
   // ----------------
   initial begin
      void'($urandom(5));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      bus(1'b0, `IDX_MODE0, 32'h0);
      chk(rd, `MODE_RESET);
      bus(1'b1, 9'h0FF, 32'h5A);
      bus(1'b0, 9'h0FF, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `IDX_STATUS, 32'hFFFF);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `IDX_GC_CELL, 32'h00);
      bus(1'b0, `IDX_GC_CELL, 32'h0);
      chk(rd[7:0], 8'h00);
      $display("registers done");
      bus(1'b1, `IDX_MODE0, 32'h3);
      foreach (cmds[i]) begin
         tele(K_GC, cmds[i]);
         if (!cmds[i][1]) chk(seen[7], cmds[i][5] || (cmds[i][4] && sync_m != 0));
         chk(seen[5], cmds[i][3]);
         chk(seen[6], cmds[i][1]);
         chk(seen[2], 1'b1);
         chk(code, A_ACK);
         sync_m = cmds[i][5] ? 1 : (cmds[i][4] ? 0 : sync_m);
         frz_m = cmds[i][3] ? 1 : (cmds[i][2] ? 0 : frz_m);
         bus(1'b0, `IDX_STATUS, 32'h0);
         chk(rd[1:0], {frz_m[0], sync_m[0]});
         bus(1'b0, `IDX_GC_CELL, 32'h0);
         chk(rd[7:0], cmds[i]);
      end
      bus(1'b1, `IDX_MODE2, 32'h100);
      tele(K_GC, 8'h02);
      chk(seen[2], 1'b0);
      tele(K_GC, 8'h04);
      chk(seen[2], 1'b1);
      $display("global control done");
      tele(K_GC, 8'h20);
      tele(K_DX, 8'h00);
      chk(seen[7], 1'b0);
      tele(K_GC, 8'h08);
      tele(K_RD_IN, 8'h00);
      chk(seen[5], 1'b0);
      tele(K_GC, 8'h04);
      tele(K_RD_IN, 8'h00);
      chk(seen[5], 1'b1);
      din_new_avail <= 1'b0;
      tele(K_RD_IN, 8'h00);
      chk(seen[5], 1'b0);
      tele(K_GC, 8'h10);
      chk(seen[7], 1'b1);
      repeat (3) begin
         user_dout_buf <= 2'($urandom);
         tele(K_RD_OUT, 8'h00);
         chk(code, A_BUFFER);
         chk(ptr, {6'h00, user_dout_buf});
      end
      $display("buffer services done");
      arm();
      bus(1'b1, `IDX_MODE1, 32'h1);
      chk(seen[4], 1'b1);
      arm();
      bus(1'b1, `IDX_MODE1, 32'h2);
      chk(seen[3], 1'b1);
      tele(K_GET_CFG, 8'h00);
      chk(code, A_ACK);
      bus(1'b1, `IDX_MODE0, 32'hF);
      tele(K_SET_PRM, 8'h00, 8'h00);
      chk(prm_fault, 1'b1);
      tele(K_SET_PRM, 8'h00);
      bus(1'b0, `IDX_STATUS, 32'h0);
      chk(rd[10:2], {8'hC0, 1'b0});
      tele(K_EXT_PRM, 8'h00);
      chk(code, A_NO_SERVICE);
      in_wait_cfg <= 1'b1;
      tele(K_EXT_PRM, 8'h00);
      chk(code, A_ACK);
      chk(seen[1], 1'b1);
      tele(K_CHK_CFG, 8'h00);
      chk(code, A_ACK);
      tele(K_EXT_PRM, 8'h00);
      chk(code, A_NO_SERVICE);
      $display("parameters done");
      q = '{8'h05, 8'h7F, 8'h7F, 8'h00, 8'h40, 8'h50, 8'h60, 8'hFF};
      bus(1'b1, `IDX_LIST_BASE, 32'h10);
      foreach (q[i]) bus(1'b1, 9'h110 + 9'(i), 32'(q[i]));
      bus(1'b1, 9'h140, 32'h10);
      bus(1'b1, 9'h141, 32'h08);
      bus(1'b1, 9'h150, 32'h00);
      tele(K_AC_REQ, 8'h00, 8'hC0, 6'h06);
      chk(code, A_NO_SERVICE);
      tele(K_AC_REQ, 8'h00);
      chk(code, A_ACK);
      chk(seen[0], 1'b1);
      bus(1'b0, 9'h140, 32'h0);
      chk(rd[7:0], 8'hC0);
      bus(1'b0, 9'h142, 32'h0);
      chk(rd[7:0], 8'h04);
      bus(1'b0, 9'h143, 32'h0);
      chk(rd[7:0], 8'h5D);
      tele(K_AC_REQ, 8'h00);
      chk(code, A_NO_RESOURCE);
      bus(1'b1, 9'h140, 32'h80);
      bus(1'b1, 9'h160, 32'hA0);
      tele(K_AC_POLL, 8'h00);
      chk(code, A_RESPONSE);
      chk(ptr, 8'h60);
      chk(seen[8], 1'b1);
      chk(seen[0], 1'b0);
      bus(1'b0, 9'h160, 32'h0);
      chk(rd[7:0], 8'h00);
      bus(1'b0, 9'h110, 32'h0);
      chk(rd[7:0], 8'h85);
      bus(1'b1, 9'h110, 32'h05);
      $display("acyclic done");
      end_sim();
   end
   initial begin
      #400000;
      mismatches++;
      end_sim();
   end
endmodule // tb_top
